// *** half_sec_tick.sv ***
/*
 * Free running prescaler giving a one cycle tick every CYCLES clocks that have the clock enable high.
 * Assumes the clock enable arrives through the carrier interface.
 */
`timescale 1ns/1ps
module half_sec_tick #(
    parameter int CYCLES = 100_000_000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    tick_if.gen       tk
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (tk.ce) begin
            if (count_reg == LAST) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    assign tk.tick = tk.ce && (count_reg == LAST);
endmodule

// *** status_display_pkg.sv ***
/*
 * Shared constants for the status display sequencer: timing, register
 * map, field positions, error code layout and segment patterns.
 * Assumes a single 200 MHz clock and segments ordered g..a, active high.
 */
// Notes on behaviour
// - no errors: hyphen lit one second, dark half a second, repeating
// - second digit dot toggles every half second as heartbeat
// - first digit dot is always dark
// - per error: group code, detailed code, blank; half second each
// - several errors shown one by one in ascending code order, wrapping
// - over twenty errors: show first twenty, then overflow code E0-01
// - all errors cleared: display returns to blinking hyphen
// - error code is E plus group digit plus two detail digits
// - groups: 0 system, 1 io, 2 network, 3 analysis
// - ready lamp lit once periodic processing has begun, dark before
// - red error lamp lit while hardware faulty or after watchdog
// - card access lamp lit only while storage card is accessed
package status_display_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_FREQ_HZ     = 200_000_000;
    localparam longint HALF_SEC_MS     = 500;
    localparam longint MS_PER_SEC      = 1000;
    localparam int     HALF_SEC_CYCLES =
        int'(CLK_FREQ_HZ * HALF_SEC_MS / MS_PER_SEC);

    // ----------------------------------------------------------------
    // register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ERR_LO = 8'h04;
    localparam logic [7:0] ADDR_ERR_HI = 8'h08;
    localparam logic [7:0] ADDR_DISP   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h14;

    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_FAULT_BIT = 1;
    localparam int CTRL_WIDTH     = 2;

    localparam int IRQ_ERR_SET   = 0;
    localparam int IRQ_ERR_CLR   = 1;
    localparam int IRQ_OVERFLOW  = 2;
    localparam int IRQ_HW_FAULT  = 3;
    localparam int IRQ_WIDTH     = 4;

    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 2'h0;
    localparam logic [IRQ_WIDTH-1:0]  MASK_RESET = 4'h0;

    // ----------------------------------------------------------------
    // error code layout: index = group * 16 + detail
    // ----------------------------------------------------------------
    localparam int         ERR_COUNT  = 64;
    localparam int         IDX_W      = 6;
    localparam int         SHOWN_W    = 5;
    localparam logic [4:0] MAX_SHOWN  = 5'h14;
    localparam logic [5:0] OVF_IDX    = 6'h01;
    localparam logic [3:0] DETAIL_TEN = 4'hA;
    localparam logic [1:0] GRP_SYSTEM   = 2'h0;
    localparam logic [1:0] GRP_IO       = 2'h1;
    localparam logic [1:0] GRP_NETWORK  = 2'h2;
    localparam logic [1:0] GRP_ANALYSIS = 2'h3;

    // ----------------------------------------------------------------
    // segments, g..a
    // ----------------------------------------------------------------
    localparam logic [6:0] SEG_BLANK  = 7'h00;
    localparam logic [6:0] SEG_HYPHEN = 7'h40;
    localparam logic [6:0] SEG_E      = 7'h79;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_ERROR, MODE_OVERFLOW}
        disp_mode_t;
    typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_OFF} phase_t;

    function automatic logic [6:0] seg_of(input logic [3:0] d);
        case (d)
            4'h0:    seg_of = 7'h3F;
            4'h1:    seg_of = 7'h06;
            4'h2:    seg_of = 7'h5B;
            4'h3:    seg_of = 7'h4F;
            4'h4:    seg_of = 7'h66;
            4'h5:    seg_of = 7'h6D;
            4'h6:    seg_of = 7'h7D;
            4'h7:    seg_of = 7'h07;
            4'h8:    seg_of = 7'h7F;
            4'h9:    seg_of = 7'h6F;
            default: seg_of = SEG_BLANK;
        endcase
    endfunction

endpackage

// *** status_display_sequencer.sv ***
/*
 * Two digit seven segment status display and status lamp driver with an
 * APB register slave and one level interrupt.
 * Assumes error sources present a level per error code index, inputs are
 * synchronous to pclk, and the APB master follows the usual protocol.
 */
`timescale 1ns/1ps
module status_display_sequencer
    import status_display_pkg::*;
#(
    parameter int HALF_CYCLES = HALF_SEC_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [ERR_COUNT-1:0] err_in,
    input  wire logic                 hw_fault_in,
    input  wire logic                 watchdog_to_in,
    input  wire logic                 card_busy_in,
    output logic      [6:0]           seg_digit0,
    output logic      [6:0]           seg_digit1,
    output logic                      dp_digit0,
    output logic                      dp_digit1,
    output logic                      periodic_run_lamp,
    output logic                      error_lamp,
    output logic                      card_access_lamp,
    output logic                      irq
);

    // ----------------------------------------------------------------
    // tick source
    // ----------------------------------------------------------------
    tick_if tk ();
    assign tk.ce = ce;

    half_sec_tick #(.CYCLES(HALF_CYCLES)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk)
    );

    logic tick;
    assign tick = tk.tick;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [ERR_COUNT-1:0]  err_sw_reg;
    logic [IRQ_WIDTH-1:0]  irq_st_reg;
    logic [IRQ_WIDTH-1:0]  irq_mk_reg;
    logic                  rd_ok_reg;
    logic [ERR_COUNT-1:0]  err_all;
    logic                  addr_ok;
    logic                  wr_en;
    logic [31:0]           rd_next;

    disp_mode_t             mode_reg;
    phase_t                 phase_reg;
    logic [IDX_W-1:0]       idx_reg;
    logic [SHOWN_W-1:0]     shown_reg;
    logic                   any_err_reg;
    logic                   fault_reg;

    assign err_all = err_in | err_sw_reg;

    // ----------------------------------------------------------------
    // apb slave: zero wait once a setup cycle has been seen under ce
    // ----------------------------------------------------------------
    always_comb begin
        addr_ok = 1'b1;
        rd_next = '0;
        unique case (paddr)
            ADDR_CTRL:   rd_next = 32'(ctrl_reg);
            ADDR_ERR_LO: rd_next = err_all[31:0];
            ADDR_ERR_HI: rd_next = err_all[63:32];
            ADDR_DISP:   rd_next = {17'h0_0000, shown_reg,
                                    2'(mode_reg), 2'(phase_reg), idx_reg};
            ADDR_IRQ_ST: rd_next = 32'(irq_st_reg);
            ADDR_IRQ_MK: rd_next = 32'(irq_mk_reg);
            default:     addr_ok = 1'b0;
        endcase
    end

    assign pready  = penable && ce && rd_ok_reg;
    assign pslverr = pready && !addr_ok;
    assign wr_en   = psel && pready && pwrite && addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ok_reg <= 1'b0;
            prdata    <= '0;
        end else if (ce) begin
            rd_ok_reg <= psel && !pready;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= CTRL_RESET;
            err_sw_reg <= '0;
            irq_mk_reg <= MASK_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_CTRL:   ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
                ADDR_ERR_LO: err_sw_reg[31:0] <= pwdata;
                ADDR_ERR_HI: err_sw_reg[63:32] <= pwdata;
                ADDR_IRQ_MK: irq_mk_reg <= pwdata[IRQ_WIDTH-1:0];
                default:     ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next error search; lowest index wins by descending scan
    // ----------------------------------------------------------------
    logic             first_found;
    logic             after_found;
    logic [IDX_W-1:0] first_idx;
    logic [IDX_W-1:0] after_idx;
    logic             frame_end;

    always_comb begin
        first_found = 1'b0;
        after_found = 1'b0;
        first_idx   = '0;
        after_idx   = '0;
        for (int i = ERR_COUNT - 1; i >= 0; i--) begin
            if (err_all[i]) begin
                first_found = 1'b1;
                first_idx   = IDX_W'(i);
                if (IDX_W'(i) > idx_reg) begin
                    after_found = 1'b1;
                    after_idx   = IDX_W'(i);
                end
            end
        end
    end

    assign frame_end = tick && (phase_reg == PH_OFF);

    // ----------------------------------------------------------------
    // phase and slot sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_FIRST;
        end else if (tick) begin
            unique case (phase_reg)
                PH_FIRST:  phase_reg <= PH_SECOND;
                PH_SECOND: phase_reg <= PH_OFF;
                PH_OFF:    phase_reg <= PH_FIRST;
                default:   phase_reg <= PH_FIRST;
            endcase
        end
    end

    // a new error waits for the current frame to end, so the display
    // never shows a partial phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= MODE_NORMAL;
            idx_reg   <= '0;
            shown_reg <= '0;
        end else if (frame_end) begin
            if (!first_found) begin
                mode_reg  <= MODE_NORMAL;
                shown_reg <= '0;
            end else if (mode_reg == MODE_ERROR && after_found &&
                         shown_reg == MAX_SHOWN) begin
                mode_reg  <= MODE_OVERFLOW;
                shown_reg <= '0;
            end else if (mode_reg == MODE_ERROR && after_found) begin
                idx_reg   <= after_idx;
                shown_reg <= shown_reg + 1'b1;
            end else begin
                mode_reg  <= MODE_ERROR;
                idx_reg   <= first_idx;
                shown_reg <= 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // digit drive
    // ----------------------------------------------------------------
    logic [IDX_W-1:0] disp_idx;
    logic [1:0]       grp;
    logic [3:0]       detail;
    logic [3:0]       tens;
    logic [3:0]       ones;

    assign disp_idx = (mode_reg == MODE_OVERFLOW) ? OVF_IDX : idx_reg;
    assign grp      = disp_idx[5:4];
    assign detail   = disp_idx[3:0];
    assign tens     = (detail >= DETAIL_TEN) ? 4'h1 : 4'h0;
    assign ones     = (detail >= DETAIL_TEN) ? detail - DETAIL_TEN : detail;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_digit0 <= SEG_BLANK;
            seg_digit1 <= SEG_BLANK;
        end else if (ce) begin
            if (mode_reg == MODE_NORMAL) begin
                if (phase_reg == PH_OFF) begin
                    seg_digit0 <= SEG_BLANK;
                    seg_digit1 <= SEG_BLANK;
                end else begin
                    seg_digit0 <= SEG_HYPHEN;
                    seg_digit1 <= SEG_HYPHEN;
                end
            end else begin
                unique case (phase_reg)
                    PH_FIRST: begin
                        seg_digit0 <= SEG_E;
                        seg_digit1 <= seg_of({2'h0, grp});
                    end
                    PH_SECOND: begin
                        seg_digit0 <= seg_of(tens);
                        seg_digit1 <= seg_of(ones);
                    end
                    default: begin
                        seg_digit0 <= SEG_BLANK;
                        seg_digit1 <= SEG_BLANK;
                    end
                endcase
            end
        end
    end

    assign dp_digit0 = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_digit1 <= 1'b0;
        end else if (tick) begin
            dp_digit1 <= !dp_digit1;
        end
    end

    // ----------------------------------------------------------------
    // lamps
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periodic_run_lamp <= 1'b0;
            error_lamp        <= 1'b0;
            card_access_lamp  <= 1'b0;
        end else if (ce) begin
            periodic_run_lamp <= ctrl_reg[CTRL_RUN_BIT];
            error_lamp        <= hw_fault_in || watchdog_to_in ||
                                 ctrl_reg[CTRL_FAULT_BIT];
            card_access_lamp  <= card_busy_in;
        end
    end

    // ----------------------------------------------------------------
    // interrupts: set wins over a same cycle write-one clear
    // ----------------------------------------------------------------
    logic [IRQ_WIDTH-1:0] irq_set;

    always_comb begin
        irq_set               = '0;
        irq_set[IRQ_ERR_SET]  = first_found && !any_err_reg;
        irq_set[IRQ_ERR_CLR]  = !first_found && any_err_reg;
        irq_set[IRQ_OVERFLOW] = frame_end && mode_reg == MODE_ERROR &&
                                after_found && shown_reg == MAX_SHOWN;
        irq_set[IRQ_HW_FAULT] = error_lamp && !fault_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_err_reg <= 1'b0;
            fault_reg   <= 1'b0;
            irq_st_reg  <= '0;
        end else if (ce) begin
            any_err_reg <= first_found;
            fault_reg   <= error_lamp;
            if (wr_en && paddr == ADDR_IRQ_ST) begin
                irq_st_reg <= (irq_st_reg & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
            end else begin
                irq_st_reg <= irq_st_reg | irq_set;
            end
        end
    end

    assign irq = |(irq_st_reg & irq_mk_reg);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dp0_dark: assert property (dp_digit0 == 1'b0)
        else $error("first digit dot lit");

    a_dp1_toggle: assert property (tick |=>
        dp_digit1 != $past(dp_digit1))
        else $error("heartbeat dot missed a toggle");

    a_dp1_hold: assert property (!tick |=> $stable(dp_digit1))
        else $error("heartbeat dot moved without a tick");

    a_hyphen_lit: assert property (ce && mode_reg == MODE_NORMAL &&
        phase_reg != PH_OFF |=> seg_digit0 == SEG_HYPHEN)
        else $error("hyphen not lit in normal lit phase");

    a_hyphen_dark: assert property (ce && mode_reg == MODE_NORMAL &&
        phase_reg == PH_OFF |=> seg_digit0 == SEG_BLANK)
        else $error("hyphen not dark in normal off phase");

    a_err_phases: assert property (ce && mode_reg != MODE_NORMAL &&
        phase_reg == PH_OFF |=> seg_digit0 == SEG_BLANK &&
        seg_digit1 == SEG_BLANK)
        else $error("error blank phase not blank");

    a_group_letter: assert property (ce && mode_reg != MODE_NORMAL &&
        phase_reg == PH_FIRST |=> seg_digit0 == SEG_E)
        else $error("group phase lacks letter E");

    a_ascending_order: assert property (frame_end &&
        mode_reg == MODE_ERROR && after_found && shown_reg < MAX_SHOWN
        |=> idx_reg > $past(idx_reg))
        else $error("errors not shown in ascending order");

    a_cap_twenty: assert property (shown_reg <= MAX_SHOWN)
        else $error("more than twenty errors shown in one sweep");

    a_overflow_slot: assert property (ce &&
        mode_reg == MODE_OVERFLOW && phase_reg == PH_SECOND
        |=> seg_digit0 == seg_of(4'h0) &&
        seg_digit1 == seg_of(OVF_IDX[3:0]))
        else $error("overflow slot shows wrong code");

    a_clear_return: assert property (frame_end && !first_found
        |=> mode_reg == MODE_NORMAL)
        else $error("display did not return to normal");

    a_error_lamp: assert property (ce && watchdog_to_in
        |=> error_lamp)
        else $error("error lamp dark after watchdog");

    a_card_lamp: assert property (ce |=> card_access_lamp ==
        $past(card_busy_in))
        else $error("card lamp does not follow access");

    a_ready_lamp: assert property (ce |=> periodic_run_lamp ==
        $past(ctrl_reg[CTRL_RUN_BIT]))
        else $error("ready lamp does not follow run state");

    c_error_shown: cover property (mode_reg == MODE_ERROR &&
        phase_reg == PH_SECOND);
    c_overflow: cover property (mode_reg == MODE_OVERFLOW);
    c_recover: cover property (mode_reg == MODE_ERROR && frame_end &&
        !first_found);
    c_irq: cover property ($rose(irq));

endmodule

// *** status_display_sequencer_test.sv ***
/*
 * Self-checking bench for the status display sequencer: APB access,
 * lamps, interrupt and the display phase sequence.
 * Assumes a shortened half second of 8 clocks and the panel model.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module status_display_sequencer_test
    import status_display_pkg::*;
;
    localparam int HC = 8;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] err_in;
    logic        hw_fault_in, watchdog_to_in, card_busy_in, irq, beat;
    logic [6:0]  seg_digit0, seg_digit1;
    logic        dp_digit0, dp_digit1, slv_err;
    logic        periodic_run_lamp, error_lamp, card_access_lamp;
    logic [13:0] face;
    int          err_total, comparisons;
    logic [6:0]  dig [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
                              7'h7D, 7'h07, 7'h7F, 7'h6F};

    status_display_sequencer #(.HALF_CYCLES(HC)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .err_in(err_in), .hw_fault_in(hw_fault_in),
        .watchdog_to_in(watchdog_to_in), .card_busy_in(card_busy_in),
        .seg_digit0(seg_digit0), .seg_digit1(seg_digit1),
        .dp_digit0(dp_digit0), .dp_digit1(dp_digit1),
        .periodic_run_lamp(periodic_run_lamp), .error_lamp(error_lamp),
        .card_access_lamp(card_access_lamp), .irq(irq));

    status_panel i_panel (
        .pclk(pclk), .presetn(presetn), .seg_digit0(seg_digit0),
        .seg_digit1(seg_digit1), .dp_digit1(dp_digit1), .face(face),
        .beat(beat));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic results();
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        q       = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // waits one heartbeat, then samples the face mid phase
    task automatic phase(output logic [13:0] f);
        int n;
        n = 0;
        do @(posedge pclk); while (beat !== 1'b1 && ++n < HC + 4);
        `CHK("heartbeat", 1'b1, beat)
        repeat (3) @(posedge pclk);
        f = face;
        `CHK("left dot", 1'b0, dp_digit0)
    endtask

    function automatic logic [13:0] ea(input int i);
        return (i < 0) ? {SEG_HYPHEN, SEG_HYPHEN} : {SEG_E, dig[i / 16]};
    endfunction

    function automatic logic [13:0] eb(input int i);
        return (i < 0) ? {SEG_HYPHEN, SEG_HYPHEN}
                       : {dig[(i % 16) / 10], dig[(i % 16) % 10]};
    endfunction

    // one frame; a negative index means the idle hyphen frame
    task automatic seq(input int i);
        logic [13:0] f;
        phase(f);
        `CHK("first", ea(i), f)
        phase(f);
        `CHK("second", eb(i), f)
        phase(f);
        `CHK("blank", 14'h0000, f)
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [13:0] f;
        int          n;
        {presetn, psel, penable, pwrite, slv_err} = 5'h00;
        {hw_fault_in, watchdog_to_in, card_busy_in} = 3'h0;
        ce          = 1'b1;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        err_in      = 64'h0;
        err_total   = 0;
        comparisons = 0;
        n           = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("ready lamp", 1'b0, periodic_run_lamp)
        apb(1'b1, ADDR_CTRL, 32'h1, rd);
        @(posedge pclk);
        `CHK("ready lamp", 1'b1, periodic_run_lamp)
        hw_fault_in <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("error lamp", 1'b1, error_lamp)
        hw_fault_in    <= 1'b0;
        watchdog_to_in <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("error lamp", 1'b1, error_lamp)
        watchdog_to_in <= 1'b0;
        card_busy_in   <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("error lamp", 1'b0, error_lamp)
        `CHK("card lamp", 1'b1, card_access_lamp)
        card_busy_in <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("card lamp", 1'b0, card_access_lamp)
        apb(1'b0, ADDR_IRQ_MK, 32'h0, rd);
        `CHK("mask reset", 32'h0, rd)
        apb(1'b0, ADDR_IRQ_ST, 32'h0, rd);
        `CHK("lamp event", 1'b1, rd[IRQ_HW_FAULT])
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, ADDR_IRQ_MK, 32'h8, rd);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, ADDR_IRQ_ST, 32'h8, rd);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b0, 8'h18, 32'h0, rd);
        `CHK("unmapped err", 1'b1, slv_err)
        `CHK("unmapped data", 32'h0, rd)
        // clock enable low must freeze the heartbeat
        ce <= 1'b0;
        @(posedge pclk);
        rd[0] = dp_digit1;
        repeat (3 * HC) @(posedge pclk);
        `CHK("frozen dot", rd[0], dp_digit1)
        ce <= 1'b1;
        do phase(f); while (f !== 14'h0000 && ++n < 6);
        seq(-1);
        err_in <= 64'h0000_0040_0000_0400;
        seq(10);
        seq(38);
        seq(10);
        seq(38);
        // 21 errors from index 16 up; slot 21 carries the overflow code
        err_in <= 64'h0000_001F_FFFF_0000;
        for (int k = 16; k < 36; k++) seq(k);
        seq(1);
        seq(16);
        err_in <= 64'h0;
        seq(-1);
        apb(1'b0, ADDR_IRQ_ST, 32'h0, rd);
        `CHK("irq events", 32'h0000_0007, rd)
        results();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule

// *** status_panel.sv ***
/*
 * Front panel model: latches both digit faces each clock and marks
 * every heartbeat dot change with a one cycle beat.
 * Assumes the display outputs are registered on pclk.
 */
`timescale 1ns/1ps
module status_panel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [6:0]  seg_digit0,
    input  wire logic [6:0]  seg_digit1,
    input  wire logic        dp_digit1,
    output logic      [13:0] face,
    output logic             beat
);
    logic dot_reg;

    // leds keep their face for a clock, like real segment persistence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            face    <= 14'h0000;
            dot_reg <= 1'b0;
            beat    <= 1'b0;
        end else begin
            face    <= {seg_digit0, seg_digit1};
            dot_reg <= dp_digit1;
            beat    <= dot_reg ^ dp_digit1;
        end
    end
endmodule

// *** tick_if.sv ***
/*
 * Carrier between the sequencer and its half second tick generator.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ps
interface tick_if;
    logic ce;
    logic tick;
    modport gen  (input ce, output tick);
    modport user (output ce, input tick);
endinterface
